// *** egress_queue_ratio_scheduler.sv ***
// four-queue egress scheduler with strict/ratio modes and an output fifo
module egress_queue_ratio_scheduler #(
  parameter int PERIOD = egress_sched_pkg::PERIOD_CYCLES,
  parameter int DEPTH  = egress_sched_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  wire logic        SYS_CLK,
  input  wire logic        RST,
  // register port
  input  wire logic [11:0] REG_ADDR,
  input  wire logic        REG_WR,
  input  wire logic [15:0] REG_WDATA,
  output logic      [15:0] REG_RDATA,
  // transmit queues: one byte stream per queue, LAST marks end of packet
  input  wire logic [3:0]  Q_VALID,
  output logic      [3:0]  Q_READY,
  input  wire logic [7:0]  Q_DATA0,
  input  wire logic [7:0]  Q_DATA1,
  input  wire logic [7:0]  Q_DATA2,
  input  wire logic [7:0]  Q_DATA3,
  input  wire logic [3:0]  Q_LAST,
  // transmit mac side
  output logic             TX_VALID,
  input  wire logic        TX_READY,
  output logic      [7:0]  TX_DATA,
  output logic             TX_LAST,
  output logic      [1:0]  TX_QUEUE,
  // status
  output logic      [3:0]  CREDIT_EMPTY
);
  localparam int PW = $clog2(PERIOD + 1);
  initial
  begin
    if (PERIOD < 2)
      $error("scheduling period must be at least 2 cycles");
  end

  typedef enum logic [1:0] {IDLE, SEND} st_e;
  typedef logic [6:0] ratio_t;

  egress_sched_pkg::qcfg_s cfg [4];
  ratio_t                  credit [4];
  logic [PW-1:0]           period_cnt;
  logic                    period_end;
  st_e                     state;
  logic [1:0]              cur_q;
  logic [1:0]              next_q;
  logic                    next_found;
  logic [3:0]              eligible;
  logic                    fifo_ready;
  logic                    beat_go;
  egress_sched_pkg::beat_s beat_in;
  egress_sched_pkg::beat_s beat_out;
  logic [7:0]              qdata [4];

  assign qdata[0] = Q_DATA0;
  assign qdata[1] = Q_DATA1;
  assign qdata[2] = Q_DATA2;
  assign qdata[3] = Q_DATA3;

  // pack two queues into one 16-bit register image
  function automatic logic [15:0] pack_pair(egress_sched_pkg::qcfg_s hi,
                                            egress_sched_pkg::qcfg_s lo);
    logic [15:0] v;
    v = '0;
    v[egress_sched_pkg::HI_CTRL_BIT]                           = hi.ratio_mode;
    v[egress_sched_pkg::HI_RATIO_LSB +: egress_sched_pkg::RATIO_W] = hi.ratio;
    v[egress_sched_pkg::LO_CTRL_BIT]                           = lo.ratio_mode;
    v[egress_sched_pkg::LO_RATIO_LSB +: egress_sched_pkg::RATIO_W] = lo.ratio;
    return v;
  endfunction

  function automatic egress_sched_pkg::qcfg_s unpack_hi(logic [15:0] v);
    return {v[egress_sched_pkg::HI_CTRL_BIT],
            v[egress_sched_pkg::HI_RATIO_LSB +: egress_sched_pkg::RATIO_W]};
  endfunction

  function automatic egress_sched_pkg::qcfg_s unpack_lo(logic [15:0] v);
    return {v[egress_sched_pkg::LO_CTRL_BIT],
            v[egress_sched_pkg::LO_RATIO_LSB +: egress_sched_pkg::RATIO_W]};
  endfunction

  // configuration registers
  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      cfg[0] <= {egress_sched_pkg::CTRL_RST, egress_sched_pkg::Q0_RATIO_RST};
      cfg[1] <= {egress_sched_pkg::CTRL_RST, egress_sched_pkg::Q1_RATIO_RST};
      cfg[2] <= {egress_sched_pkg::CTRL_RST, egress_sched_pkg::Q2_RATIO_RST};
      cfg[3] <= {egress_sched_pkg::CTRL_RST, egress_sched_pkg::Q3_RATIO_RST};
    end
    else if (REG_WR && REG_ADDR == egress_sched_pkg::UPPER_RATIO_OFS)
    begin
      cfg[2] <= unpack_hi(REG_WDATA);
      cfg[3] <= unpack_lo(REG_WDATA);
    end
    else if (REG_WR && REG_ADDR == egress_sched_pkg::LOWER_RATIO_OFS)
    begin
      cfg[0] <= unpack_hi(REG_WDATA);
      cfg[1] <= unpack_lo(REG_WDATA);
    end
  end

  // reads are combinational on the documented port; unmapped offsets read zero
  always_comb
  begin
    unique case (REG_ADDR)
      egress_sched_pkg::UPPER_RATIO_OFS: REG_RDATA = pack_pair(cfg[2], cfg[3]);
      egress_sched_pkg::LOWER_RATIO_OFS: REG_RDATA = pack_pair(cfg[0], cfg[1]);
      default:                           REG_RDATA = 16'h0000;
    endcase
  end

  // period timer
  assign period_end = (period_cnt == PW'(PERIOD - 1));
  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
      period_cnt <= '0;
    else if (period_end)
      period_cnt <= '0;
    else
      period_cnt <= period_cnt + 1'b1;
  end

  // a queue may start a packet when it has data and, in ratio mode, credit left
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      eligible[i]     = Q_VALID[i] && (!cfg[i].ratio_mode || credit[i] != '0);
      CREDIT_EMPTY[i] = cfg[i].ratio_mode && credit[i] == '0;
    end
  end

  // highest queue first; a strict queue with data blocks all below it
  always_comb
  begin
    next_q     = 2'd0;
    next_found = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      if (eligible[i])
      begin
        next_q     = 2'(i);
        next_found = 1'b1;
      end
    end
  end

  assign beat_go = (state == SEND) && Q_VALID[cur_q] && fifo_ready;

  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      state <= IDLE;
      cur_q <= 2'd0;
    end
    else
    begin
      unique case (state)
        IDLE:
        begin
          if (next_found)
          begin
            state <= SEND;
            cur_q <= next_q;
          end
        end
        SEND:
        begin
          // packets are never cut: the queue keeps the port until its last byte
          if (beat_go && Q_LAST[cur_q])
            state <= IDLE;
        end
      endcase
    end
  end

  // credits: one per ratio-mode packet started, all reloaded at period end; a start in that cycle costs none
  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      credit[0] <= egress_sched_pkg::Q0_RATIO_RST;
      credit[1] <= egress_sched_pkg::Q1_RATIO_RST;
      credit[2] <= egress_sched_pkg::Q2_RATIO_RST;
      credit[3] <= egress_sched_pkg::Q3_RATIO_RST;
    end
    else
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (period_end)
          credit[i] <= cfg[i].ratio;
        else if (state == IDLE && next_found && next_q == 2'(i) && cfg[i].ratio_mode)
          credit[i] <= credit[i] - 1'b1;
      end
    end
  end

  always_comb
  begin
    Q_READY = 4'b0000;
    if (state == SEND && fifo_ready)
      Q_READY[cur_q] = 1'b1;
  end

  assign beat_in = '{data: qdata[cur_q], last: Q_LAST[cur_q], queue: cur_q};

  egress_fifo #(
    .WIDTH (egress_sched_pkg::BEAT_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .SYS_CLK   (SYS_CLK),
    .RST       (RST),
    .in_valid  (beat_go),
    .in_ready  (fifo_ready),
    .in_data   (beat_in),
    .out_valid (TX_VALID),
    .out_ready (TX_READY),
    .out_data  (beat_out)
  );

  assign TX_DATA  = beat_out.data;
  assign TX_LAST  = beat_out.last;
  assign TX_QUEUE = beat_out.queue;

  // a strict queue with data must win over every lower queue
  strict_q3_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    state == IDLE && Q_VALID[3] && !cfg[3].ratio_mode |=> state == SEND && cur_q == 2'd3)
    else $error("strict queue 3 not chosen");
  strict_q2_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    state == IDLE && Q_VALID[2] && !cfg[2].ratio_mode && !eligible[3] |=> cur_q == 2'd2)
    else $error("strict queue 2 not chosen");
  strict_q1_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    state == IDLE && Q_VALID[1] && !cfg[1].ratio_mode && eligible[3:2] == 2'b00 |=> cur_q == 2'd1)
    else $error("strict queue 1 not chosen");
  low_last_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    state == IDLE && next_found && next_q == 2'd0 |-> eligible[3:1] == 3'b000)
    else $error("queue 0 chosen over higher queue");
  ratio_q2_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    state == IDLE && cfg[2].ratio_mode && credit[2] == 7'h00 |-> !(next_found && next_q == 2'd2))
    else $error("queue 2 sent without credit");
  ratio_q3_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    state == IDLE && next_found && next_q == 2'd3 && cfg[3].ratio_mode && !period_end
    |=> credit[3] == $past(credit[3]) - 7'h01)
    else $error("queue 3 credit not spent");
  ratio_q0_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    state == IDLE && cfg[0].ratio_mode && credit[0] == 7'h00 |-> !(next_found && next_q == 2'd0))
    else $error("queue 0 sent without credit");
  ratio_q1_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    state == IDLE && cfg[1].ratio_mode && credit[1] == 7'h00 |-> !(next_found && next_q == 2'd1))
    else $error("queue 1 sent without credit");
  reload_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    period_end |=> credit[0] == $past(cfg[0].ratio) && credit[3] == $past(cfg[3].ratio))
    else $error("credits not reloaded");
  reg_rw_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    REG_WR && REG_ADDR == egress_sched_pkg::UPPER_RATIO_OFS
    |=> pack_pair(cfg[2], cfg[3]) == $past(REG_WDATA))
    else $error("upper register write lost");
  reg_lo_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    REG_WR && REG_ADDR == egress_sched_pkg::LOWER_RATIO_OFS
    |=> pack_pair(cfg[0], cfg[1]) == $past(REG_WDATA))
    else $error("lower register write lost");

  pkt_done_c: cover property (@(posedge SYS_CLK) disable iff (RST) beat_go && Q_LAST[cur_q]);
  credit_out_c: cover property (@(posedge SYS_CLK) disable iff (RST) CREDIT_EMPTY[3] && Q_VALID[3]);
  fifo_full_c: cover property (@(posedge SYS_CLK) disable iff (RST) state == SEND && !fifo_ready);
  strict_c: cover property (@(posedge SYS_CLK) disable iff (RST)
    state == IDLE && next_found && !cfg[next_q].ratio_mode);
endmodule

// *** egress_sched_pkg.sv ***
// constants and carrier types for the egress queue ratio scheduler
// Operation
// - with the queue-2 control bit clear, every waiting queue-2 packet goes before any lower queue.
// - with the queue-2 control bit set, queue-2 sends at most its ratio count per period.
// - the queue-2 ratio field is read/write and resets to 0x04.
// - with the queue-3 control bit clear, queue-3 is drained before any lower queue.
// - with the queue-3 control bit set, queue-3 sends at most its ratio count per period.
// - the queue-3 ratio field is read/write and resets to 0x08.
// - with the queue-0 control bit clear, queue-0 sends only after all higher queues are served.
// - with the queue-0 control bit set, queue-0 sends at most its ratio count per period.
// - the queue-0 ratio field is read/write and resets to 0x01.
// - with the queue-1 control bit clear, queue-1 is drained before lower queues.
// - with the queue-1 control bit set, queue-1 sends at most its ratio count per period.
// - the queue-1 ratio field is read/write and resets to 0x02.
package egress_sched_pkg;
  localparam logic [11:0] UPPER_RATIO_OFS = 12'h0D0;
  localparam logic [11:0] LOWER_RATIO_OFS = 12'h0D2;
  localparam int          HI_CTRL_BIT     = 15;
  localparam int          HI_RATIO_LSB    = 8;
  localparam int          LO_CTRL_BIT     = 7;
  localparam int          LO_RATIO_LSB    = 0;
  localparam int          RATIO_W         = 7;
  localparam logic [6:0]  Q0_RATIO_RST    = 7'h01;
  localparam logic [6:0]  Q1_RATIO_RST    = 7'h02;
  localparam logic [6:0]  Q2_RATIO_RST    = 7'h04;
  localparam logic [6:0]  Q3_RATIO_RST    = 7'h08;
  localparam logic        CTRL_RST        = 1'b1;
  localparam int          NUM_QUEUES      = 4;
  localparam int          PERIOD_CYCLES   = 40000;
  localparam int          FIFO_DEPTH      = 16;
  localparam int          DATA_W          = 8;

  typedef struct packed {
    logic [7:0] data;
    logic       last;
    logic [1:0] queue;
  } beat_s;
  localparam int BEAT_W = $bits(beat_s);

  typedef struct packed {
    logic             ratio_mode;
    logic [6:0]       ratio;
  } qcfg_s;
endpackage

// *** egress_fifo.sv ***
// width/depth parameterised fifo with registered read data
module egress_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             SYS_CLK,
  input  wire logic             RST,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  initial
  begin
    if (DEPTH < 2 || (1 << AW) != DEPTH)
      $error("fifo depth must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic             push;
  logic             pop;
  logic             full;
  logic             empty;

  assign full     = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign empty    = (wr_ptr == rd_ptr);
  assign in_ready = !full;
  // out stage holds one word so read data always come from a register
  assign pop      = !empty && (!out_valid || out_ready);
  assign push     = in_valid && !full;

  always_ff @(posedge SYS_CLK)
  begin
    if (push)
      mem[wr_ptr[AW-1:0]] <= in_data;
  end

  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
      wr_ptr <= '0;
    else if (push)
      wr_ptr <= wr_ptr + 1'b1;
  end

  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
      rd_ptr <= '0;
    else if (pop)
      rd_ptr <= rd_ptr + 1'b1;
  end

  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end
    else if (pop)
    begin
      out_valid <= 1'b1;
      out_data  <= mem[rd_ptr[AW-1:0]];
    end
    else if (out_ready)
      out_valid <= 1'b0;
  end
endmodule

// *** tx_mac_model.sv ***
// transmit mac stand-in: random back-pressure, reports every accepted beat
module tx_mac_model (
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst,
  // stream from the scheduler
  input  wire logic                    tx_valid,
  output logic                         tx_ready,
  input  wire logic [7:0]              tx_data,
  input  wire logic                    tx_last,
  input  wire logic [1:0]              tx_queue,
  // report to the bench
  output logic                         got,
  output egress_sched_pkg::beat_s      beat
);
  timeunit 1ns;
  timeprecision 1ps;

  always @(posedge clk or posedge rst)
    if (rst)
    begin
      tx_ready <= 1'b0;
      got      <= 1'b0;
      beat     <= '0;
    end
    else
    begin
      // stalls half the time so the scheduler fifo backs up
      tx_ready <= 1'($urandom);
      got      <= tx_valid && tx_ready;
      beat     <= '{data: tx_data, last: tx_last, queue: tx_queue};
    end
endmodule

// *** egress_queue_ratio_scheduler_tb.sv ***
// self-checking bench for the egress queue ratio scheduler
module egress_queue_ratio_scheduler_tb;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin n_fail++; \
    $display("Error %s expected %h seen %h", nm, e, s); end end
  localparam int          P  = 400;
  localparam logic [11:0] UP = egress_sched_pkg::UPPER_RATIO_OFS;
  localparam logic [11:0] LO = egress_sched_pkg::LOWER_RATIO_OFS;
  localparam logic [15:0] UP_RST = {egress_sched_pkg::CTRL_RST, egress_sched_pkg::Q2_RATIO_RST,
                                    egress_sched_pkg::CTRL_RST, egress_sched_pkg::Q3_RATIO_RST};
  localparam logic [15:0] LO_RST = {egress_sched_pkg::CTRL_RST, egress_sched_pkg::Q0_RATIO_RST,
                                    egress_sched_pkg::CTRL_RST, egress_sched_pkg::Q1_RATIO_RST};
  logic                    sys_clk = 1'b0;
  logic                    rst = 1'b1;
  logic [11:0]             reg_addr = '0;
  logic                    reg_wr = 1'b0;
  logic [15:0]             reg_wdata = '0;
  logic [15:0]             reg_rdata;
  logic [3:0]              q_valid;
  logic [3:0]              q_ready;
  logic [3:0]              q_last = '0;
  logic [3:0]              mid = '0;
  logic [3:0]              credit_empty;
  logic [7:0]              q_data [4] = '{default: '0};
  logic [15:0]             pending [4] = '{default: '0};
  logic                    tx_valid, tx_ready, tx_last, got;
  logic [7:0]              tx_data;
  logic [1:0]              tx_queue;
  egress_sched_pkg::beat_s beat;
  egress_sched_pkg::beat_s exp_q [$];
  int                      n_fail = 0, n_compared = 0, cyc = 0, cur_b = 0, last = 3;
  int                      full_from = 1 << 30;
  int                      cnt [4] = '{default: 0};
  int                      ratio [4];

  always #12.5 sys_clk = ~sys_clk;
  for (genvar g = 0; g < 4; g++)
  begin : g_valid
    assign q_valid[g] = pending[g] != '0;
  end

  egress_queue_ratio_scheduler #(.PERIOD(P), .DEPTH(egress_sched_pkg::FIFO_DEPTH))
    i_egress_queue_ratio_scheduler (
    .SYS_CLK(sys_clk), .RST(rst), .REG_ADDR(reg_addr), .REG_WR(reg_wr),
    .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .Q_VALID(q_valid), .Q_READY(q_ready),
    .Q_DATA0(q_data[0]), .Q_DATA1(q_data[1]), .Q_DATA2(q_data[2]), .Q_DATA3(q_data[3]),
    .Q_LAST(q_last), .TX_VALID(tx_valid), .TX_READY(tx_ready), .TX_DATA(tx_data),
    .TX_LAST(tx_last), .TX_QUEUE(tx_queue), .CREDIT_EMPTY(credit_empty));

  tx_mac_model i_tx_mac_model (
    .clk(sys_clk), .rst(rst), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
    .tx_last(tx_last), .tx_queue(tx_queue), .got(got), .beat(beat));

  // queue sources, packet-start bookkeeping per period bucket, and tx comparison
  always @(posedge sys_clk)
  begin
    int b;
    egress_sched_pkg::beat_s e;
    cyc <= rst ? 0 : cyc + 1;
    for (int i = 0; i < 4; i++)
      if (q_valid[i] && q_ready[i])
      begin
        exp_q.push_back('{data: q_data[i], last: q_last[i], queue: 2'(i)});
        if (!mid[i])
        begin
          // bucket offset keeps a few cycles of period skew from splitting a burst
          b = (cyc + P / 4) / P;
          if (b != cur_b)
          begin
            for (int k = 0; k < 4; k++)
              if (cur_b >= full_from)
                `CHK("packets per period", ratio[k], cnt[k])
            cnt = '{default: 0};
            last = 3;
            cur_b = b;
          end
          `CHK("priority order", 1'b1, i <= last)
          last = i;
          cnt[i]++;
        end
        mid[i] <= !q_last[i];
        if (q_last[i])
          pending[i] <= pending[i] - 16'h0001;
        q_data[i] <= 8'($urandom);
        q_last[i] <= 1'($urandom);
      end
    if (cyc % P == 300 && cyc / P >= full_from)
      `CHK("credit empty", 4'hF, credit_empty)
    if (got)
    begin
      if (exp_q.size() == 0)
        `CHK("tx beat present", 1'b1, 1'b0)
      else
      begin
        e = exp_q.pop_front();
        `CHK("tx beat", e, beat)
      end
    end
  end

  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [15:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    @(negedge sys_clk);
    `CHK("register read", e, reg_rdata)
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    logic [15:0] v;
    int          k;
    v = 16'($urandom(1));
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    rd(UP, UP_RST);
    rd(LO, LO_RST);
    for (k = 0; k < 4; k++)
    begin
      v = 16'($urandom);
      wr(k[0] ? LO : UP, v);
      rd(k[0] ? LO : UP, v);
    end
    wr(12'h0D4, 16'hFFFF);
    rd(12'h0D4, 16'h0000);
    rd(LO, v);
    // strict everywhere: six packets per queue, more than any small ratio
    wr(UP, 16'h7F7F & 16'($urandom));
    wr(LO, 16'h7F7F & 16'($urandom));
    last = 3;
    for (k = 0; k < 4; k++)
      pending[k] <= 16'h0006;
    @(posedge sys_clk);
    for (k = 0; k < 4000 && (q_valid != '0 || exp_q.size() != 0); k++)
      @(posedge sys_clk);
    if (k == 4000)
    begin
      n_fail++;
      wrap_up();
    end
    // ratio everywhere with endless backlog; small random ratios
    for (k = 0; k < 4; k++)
      ratio[k] = 1 + $urandom % 3;
    wr(UP, {1'b1, 7'(ratio[2]), 1'b1, 7'(ratio[3])});
    wr(LO, {1'b1, 7'(ratio[0]), 1'b1, 7'(ratio[1])});
    last = 3;
    full_from = (cyc + P / 4) / P + 2;
    for (k = 0; k < 4; k++)
      pending[k] <= 16'hFFFF;
    repeat (8 * P) @(posedge sys_clk);
    wrap_up();
  end
endmodule
